// [src/srpp_consts.svh]
// constants of the serial register programming port
`ifndef SRPP_CONSTS_SVH
`define SRPP_CONSTS_SVH
`define SRPP_WORD_W 32
`define SRPP_ADDR_W 4
`define SRPP_DATA_W 28
`define SRPP_ADDR_LSB 0
`define SRPP_DATA_LSB 4
`define SRPP_NUM_REGS 16
`define SRPP_ADDR_CAL 4'h0
`define SRPP_ADDR_DIVSYNC 4'h4
`define SRPP_ADDR_RESET 4'h7
`define SRPP_DIV_SYNC_A 6'h04
`define SRPP_DIV_SYNC_B 6'h05
`define SRPP_REG_DEFAULT 28'h0000000
`define SRPP_SYNC_STAGES 3
`endif

// [src/srpp_pkg.sv]
// types of the serial register programming port
package srpp_pkg;
    typedef logic [3:0] srpp_addr_t;
    typedef logic [27:0] srpp_data_t;
    typedef logic [31:0] srpp_word_t;
    typedef logic [5:0] srpp_div_t;
endpackage

// [src/srpp_in_sync.sv]
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module srpp_in_sync #(
    parameter bit INIT = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg, fall_reg;
    logic level_next, rise_next, fall_next;

    // level follows the input only once stages two and three agree; edges come from level
    always_comb begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
        rise_next = level_next & ~level_reg;
        fall_next = ~level_next & level_reg;
    end

    // synchroniser chain and edge flags
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            level_reg <= INIT;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign level = level_reg;
    assign rise = rise_reg;
    assign fall = fall_reg;
endmodule // srpp_in_sync

// [src/srpp_port.sv]
// serial register programming port: shift register, register bank, event pulses
`timescale 1ns/10ps
`include "srpp_consts.svh"
module srpp_port (
    input wire logic clk,
    input wire logic srst,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic loadStrobe,
    input wire logic fullChipMode,
    input wire logic rfOutEnable,
    input wire logic [5:0] outputDividerValue,
    input wire logic [3:0] cfgRdAddr,
    output logic [27:0] cfgRdData,
    output logic wrPulse,
    output logic [3:0] wrAddr,
    output logic [27:0] wrData,
    output logic restorePulse,
    output logic calStartPulse,
    output logic divSyncPulse
);
    logic [2:0] pinIn, pinLevel, pinRise, pinFall;
    logic sclkRise, sdataLevel, strobeLevel, strobeRise, strobeFall;

    assign pinIn = {loadStrobe, serialData, serialClk};

    // one synchroniser per pin; strobe idles high
    generate
        for (genvar i = 0; i < `SRPP_SYNC_STAGES; i++) begin : g_sync
            srpp_in_sync #(.INIT(i == 2)) u_sync (
                .clk(clk),
                .srst(srst),
                .din(pinIn[i]),
                .level(pinLevel[i]),
                .rise(pinRise[i]),
                .fall(pinFall[i])
            );
        end
    endgenerate

    assign sclkRise = pinRise[0];
    assign sdataLevel = pinLevel[1];
    assign strobeLevel = pinLevel[2];
    assign strobeRise = pinRise[2];
    assign strobeFall = pinFall[2];

    // field decode used by several processes
    function automatic srpp_pkg::srpp_addr_t addrOf(input srpp_pkg::srpp_word_t w);
        addrOf = w[`SRPP_ADDR_LSB +: `SRPP_ADDR_W];
    endfunction

    function automatic srpp_pkg::srpp_data_t dataOf(input srpp_pkg::srpp_word_t w);
        dataOf = w[`SRPP_DATA_LSB +: `SRPP_DATA_W];
    endfunction

    srpp_pkg::srpp_word_t shift_reg, shift_next;
    logic wrPulse_reg, wrPulse_next;
    srpp_pkg::srpp_addr_t wrAddr_reg, wrAddr_next;
    srpp_pkg::srpp_data_t wrData_reg, wrData_next;
    logic restorePend_reg, restorePend_next;
    logic calPend_reg, calPend_next;
    logic restorePulse_reg, restorePulse_next;
    logic calStartPulse_reg, calStartPulse_next;
    logic divSyncPulse_reg, divSyncPulse_next;
    logic divIsSync;

    assign divIsSync = (outputDividerValue == `SRPP_DIV_SYNC_A) ||
                       (outputDividerValue == `SRPP_DIV_SYNC_B);

    // next state of shift register, latch and event logic
    always_comb begin
        shift_next = shift_reg;
        wrPulse_next = 1'b0;
        wrAddr_next = wrAddr_reg;
        wrData_next = wrData_reg;
        restorePend_next = restorePend_reg;
        calPend_next = calPend_reg;
        restorePulse_next = 1'b0;
        calStartPulse_next = 1'b0;
        divSyncPulse_next = 1'b0;
        if (!strobeLevel && sclkRise) begin
            shift_next = {shift_reg[30:0], sdataLevel};
        end
        if (strobeRise) begin
            wrPulse_next = 1'b1;
            wrAddr_next = addrOf(shift_reg);
            wrData_next = dataOf(shift_reg);
            restorePend_next = (addrOf(shift_reg) == `SRPP_ADDR_RESET);
            calPend_next = (addrOf(shift_reg) == `SRPP_ADDR_CAL);
            divSyncPulse_next = (addrOf(shift_reg) == `SRPP_ADDR_DIVSYNC) &&
                                rfOutEnable && divIsSync;
        end
        if (strobeFall) begin
            restorePulse_next = restorePend_reg;
            calStartPulse_next = calPend_reg && fullChipMode;
            restorePend_next = 1'b0;
            calPend_next = 1'b0;
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_reg <= '0;
            wrPulse_reg <= 1'b0;
            wrAddr_reg <= '0;
            wrData_reg <= '0;
            restorePend_reg <= 1'b0;
            calPend_reg <= 1'b0;
            restorePulse_reg <= 1'b0;
            calStartPulse_reg <= 1'b0;
            divSyncPulse_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            wrPulse_reg <= wrPulse_next;
            wrAddr_reg <= wrAddr_next;
            wrData_reg <= wrData_next;
            restorePend_reg <= restorePend_next;
            calPend_reg <= calPend_next;
            restorePulse_reg <= restorePulse_next;
            calStartPulse_reg <= calStartPulse_next;
            divSyncPulse_reg <= divSyncPulse_next;
        end
    end

    // register bank with restore to defaults
    srpp_pkg::srpp_data_t bank [`SRPP_NUM_REGS];
    srpp_pkg::srpp_data_t bank_next [`SRPP_NUM_REGS];
    srpp_pkg::srpp_data_t cfgRdData_reg, cfgRdData_next;

    // next bank contents: a restore clears every entry, a load writes one
    always_comb begin
        bank_next = bank;
        if (strobeFall && restorePend_reg) begin
            for (int k = 0; k < `SRPP_NUM_REGS; k++) begin
                bank_next[k] = `SRPP_REG_DEFAULT;
            end
        end else if (strobeRise) begin
            bank_next[addrOf(shift_reg)] = dataOf(shift_reg);
        end
    end

    // bank storage
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int k = 0; k < `SRPP_NUM_REGS; k++) begin
                bank[k] <= `SRPP_REG_DEFAULT;
            end
        end else begin
            bank <= bank_next;
        end
    end

    // read port mux
    always_comb begin
        cfgRdData_next = bank[cfgRdAddr];
    end

    // read port register
    always_ff @(posedge clk) begin
        if (srst) begin
            cfgRdData_reg <= '0;
        end else begin
            cfgRdData_reg <= cfgRdData_next;
        end
    end

    assign cfgRdData = cfgRdData_reg;
    assign wrPulse = wrPulse_reg;
    assign wrAddr = wrAddr_reg;
    assign wrData = wrData_reg;
    assign restorePulse = restorePulse_reg;
    assign calStartPulse = calStartPulse_reg;
    assign divSyncPulse = divSyncPulse_reg;

    // checks
    property p_shift;
        @(posedge clk) disable iff (srst)
        (!strobeLevel && sclkRise) |=> (shift_reg == {$past(shift_reg[30:0]), $past(sdataLevel)});
    endproperty
    a_shift: assert property (p_shift) else $error("shift register missed a bit");

    property p_hold;
        @(posedge clk) disable iff (srst)
        strobeLevel |=> $stable(shift_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("shift register moved while strobe high");

    property p_addr;
        @(posedge clk) disable iff (srst)
        strobeRise |=> wrPulse_reg && (wrAddr_reg == $past(shift_reg[3:0]));
    endproperty
    a_addr: assert property (p_addr) else $error("wrong address field");

    property p_data;
        @(posedge clk) disable iff (srst)
        strobeRise |=> (wrData_reg == $past(shift_reg[31:4]));
    endproperty
    a_data: assert property (p_data) else $error("wrong data field");

    sequence s_written;
        ##1 (bank[wrAddr_reg] == wrData_reg);
    endsequence
    property p_store;
        @(posedge clk) disable iff (srst)
        strobeRise |-> s_written;
    endproperty
    a_store: assert property (p_store) else $error("register not written on strobe rise");

    sequence s_restored;
        ##1 restorePulse_reg ##0 (bank[`SRPP_ADDR_RESET] == `SRPP_REG_DEFAULT)
            ##0 (bank[`SRPP_ADDR_CAL] == `SRPP_REG_DEFAULT);
    endsequence
    property p_restore;
        @(posedge clk) disable iff (srst)
        (strobeFall && restorePend_reg) |-> s_restored;
    endproperty
    a_restore: assert property (p_restore) else $error("defaults not restored");

    property p_cal;
        @(posedge clk) disable iff (srst)
        strobeFall |=> (calStartPulse_reg == ($past(calPend_reg) && $past(fullChipMode)));
    endproperty
    a_cal: assert property (p_cal) else $error("calibration start wrong");

    property p_div;
        @(posedge clk) disable iff (srst)
        (strobeRise && shift_reg[3:0] == `SRPP_ADDR_DIVSYNC && rfOutEnable && divIsSync)
        |=> divSyncPulse_reg ##1 !divSyncPulse_reg;
    endproperty
    a_div: assert property (p_div) else $error("divider resync missing");
endmodule // srpp_port

// [verification/srpp_host.sv]
// host model that drives three-wire serial writes into the port
`timescale 1ns/10ps
module srpp_host (
    input wire logic clk,
    output logic serialClk,
    output logic serialData,
    output logic loadStrobe
);
    // serial clock stands still low outside frames, strobe idles high until the first frame
    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        loadStrobe = 1'b1;
    end
    // wait whole system cycles, then step off the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // shift n bits msb first at a 160 ns serial period, then load and drop the strobe
    task automatic send(input logic [39:0] w, input int n);
        loadStrobe = 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            serialData = w[i];
            tick(4);
            serialClk = 1'b1;
            tick(4);
            serialClk = 1'b0;
        end
        serialData = ~serialData; // released line must not keep the last bit
        tick(4);
        loadStrobe = 1'b1;
        tick(8);
        loadStrobe = 1'b0;
        tick(12);
    endtask
endmodule // srpp_host

// [verification/srpp_port_tb.sv]
// self-checking bench of the serial register programming port
`timescale 1ns/10ps
module srpp_port_tb;
    logic clk, srst, serialClk, serialData, loadStrobe, fullChipMode, rfOutEnable;
    logic [5:0] outputDividerValue;
    logic [3:0] cfgRdAddr, wrAddr;
    logic [27:0] cfgRdData, wrData;
    logic wrPulse, restorePulse, calStartPulse, divSyncPulse;
    int err_total = 0, n_tests = 0, nWr = 0, nRst = 0, nCal = 0, nDiv = 0;
    srpp_port srpp_port_inst (.clk(clk), .srst(srst), .serialClk(serialClk),
        .serialData(serialData), .loadStrobe(loadStrobe), .fullChipMode(fullChipMode),
        .rfOutEnable(rfOutEnable), .outputDividerValue(outputDividerValue),
        .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData), .wrPulse(wrPulse), .wrAddr(wrAddr),
        .wrData(wrData), .restorePulse(restorePulse), .calStartPulse(calStartPulse),
        .divSyncPulse(divSyncPulse));
    srpp_host srpp_host_inst (.clk(clk), .serialClk(serialClk), .serialData(serialData),
        .loadStrobe(loadStrobe));
    // clock generation
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count every one-cycle event pulse
    always @(posedge clk) begin
        if (wrPulse === 1'b1) nWr <= nWr + 1;
        if (restorePulse === 1'b1) nRst <= nRst + 1;
        if (calStartPulse === 1'b1) nCal <= nCal + 1;
        if (divSyncPulse === 1'b1) nDiv <= nDiv + 1;
    end
    // compare one value against its expectation
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // send one frame and check the loaded word and the pulses it caused
    task automatic wr(input logic [39:0] w, input int n, input int eR, input int eC,
            input int eD);
        int w0, r0, c0, d0;
        w0 = nWr;
        r0 = nRst;
        c0 = nCal;
        d0 = nDiv;
        srpp_host_inst.send(w, n);
        chk(nWr - w0, 1);
        chk(nRst - r0, eR);
        chk(nCal - c0, eC);
        chk(nDiv - d0, eD);
        chk({wrData, wrAddr}, w[31:0]);
    endtask
    // read one register of the bank
    task automatic rd(input logic [3:0] a, input logic [27:0] exp);
        cfgRdAddr = a;
        repeat (2) @(posedge clk);
        #1;
        chk({4'h0, cfgRdData}, {4'h0, exp});
    endtask
    task automatic t_write();
        wr({8'h00, 28'ha5c3e17, 4'h3}, 32, 0, 0, 0);
        rd(4'h3, 28'ha5c3e17);
        $display("test write done");
    endtask
    task automatic t_long();
        wr({8'hff, 28'h1234567, 4'h5}, 40, 0, 0, 0);
        rd(4'h5, 28'h1234567);
        $display("test long frame done");
    endtask
    task automatic t_reset();
        wr({8'h00, 28'h7777777, 4'h7}, 32, 1, 0, 0);
        rd(4'h3, 28'h0000000);
        rd(4'h5, 28'h0000000);
        rd(4'h7, 28'h0000000);
        $display("test restore done");
    endtask
    task automatic t_div();
        for (int e = 0; e < 2; e++) begin
            for (int v = 3; v < 6; v++) begin
                rfOutEnable = e[0];
                outputDividerValue = v[5:0];
                wr({8'h00, 28'h0000040, 4'h4}, 32, 0, 0, (e == 1 && v > 3) ? 1 : 0);
            end
        end
        rd(4'h4, 28'h0000040);
        $display("test divider sync done");
    endtask
    task automatic t_cal();
        fullChipMode = 1'b0;
        wr({8'h00, 28'h0abcdef, 4'h0}, 32, 0, 0, 0);
        fullChipMode = 1'b1;
        wr({8'h00, 28'h0abcdef, 4'h0}, 32, 0, 1, 0);
        $display("test calibration done");
    endtask
    // print counts and verdict, then stop
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog well beyond the roughly 65 us that the tests take
    initial begin
        #500000;
        err_total++;
        finish_test();
    end
    // reset, then run the scenarios
    initial begin
        srst = 1'b1;
        fullChipMode = 1'b1;
        rfOutEnable = 1'b1;
        outputDividerValue = 6'h04;
        cfgRdAddr = 4'h0;
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_write();
        t_long();
        t_reset();
        t_div();
        t_cal();
        finish_test();
    end
endmodule // srpp_port_tb
